//--- rtl/pcpc_pkg.sv
// Purpose: Shared constants and types for the PSRAM configuration and power controller
// Assumes: 200 MHz controller clock, asynchronous register accesses on the multiplexed bus
// Notes:   Software-facing map is word-indexed by byte offsets 0x0, 0x4, 0x8, 0xc
package pcpc_pkg;

  // Software-facing register map
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_WDATA  = 4'h4;
  localparam logic [3:0] ADDR_RDATA  = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  // Control word fields
  localparam int CTRL_START    = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_SEL_LSB  = 4;
  localparam int CTRL_WAKE     = 8;

  // Status word fields
  localparam int STAT_BUSY    = 0;
  localparam int STAT_ASLEEP  = 1;
  localparam int STAT_INIT    = 2;
  localparam int STAT_WAIT    = 3;
  localparam int STAT_REFUSED = 4;

  // Access modes
  localparam logic [1:0] MODE_CRE_WR = 2'h0;
  localparam logic [1:0] MODE_CRE_RD = 2'h1;
  localparam logic [1:0] MODE_SW_WR  = 2'h2;
  localparam logic [1:0] MODE_SW_RD  = 2'h3;

  // Register selection, equal to the select-pin address code on A[19:18]
  localparam logic [1:0] SEL_REFRESH  = 2'h0;
  localparam logic [1:0] SEL_IDENTITY = 2'h1;
  localparam logic [1:0] SEL_BUS      = 2'h2;
  localparam int         CRE_SEL_LSB  = 2;

  // Third-operation data codes of the software sequence
  localparam logic [15:0] SW_CODE_REFRESH  = 16'h0000;
  localparam logic [15:0] SW_CODE_BUS      = 16'h0001;
  localparam logic [15:0] SW_CODE_IDENTITY = 16'h0002;

  // Device side
  localparam logic [21:0] TOP_ADDR        = 22'h3fffff;
  localparam logic [21:0] ARRAY_RD_ADDR   = 22'h000000;
  localparam logic [15:0] BUS_SETUP_RESET = 16'h9d1f;

  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int T_ADV_NS      = 10;
  localparam int T_ACC_NS      = 70;
  localparam int T_GAP_NS      = 10;
  localparam int T_WAKE_US     = 10;
  localparam int T_INIT_US     = 150;
  localparam int SYNC_STAGES   = 2;

  localparam logic [15:0] ADV_CYC  = 16'((T_ADV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] ACC_CYC  = 16'((T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] DATA_CYC = 16'(ACC_CYC + SYNC_STAGES + 1);
  localparam logic [15:0] GAP_CYC  = 16'((T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] WAKE_CYC = 16'((T_WAKE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] INIT_CYC_DFLT = 16'((T_INIT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  // Data source of one bus operation
  localparam logic [1:0] DSRC_NONE  = 2'h0;
  localparam logic [1:0] DSRC_SEL   = 2'h1;
  localparam logic [1:0] DSRC_WDATA = 2'h2;

  typedef struct packed {
    logic       wr;
    logic       config_reg_select;
    logic       top;
    logic [1:0] dsrc;
    logic       cap;
  } pcpc_op_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_GAP,
    ST_WAKE,
    ST_INIT
  } pcpc_state_e;

endpackage

//--- rtl/pcpc_ctrl.sv
// Purpose: Host controller that loads and reads PSRAM configuration registers and
//          drives deep sleep entry and exit through the device pins
// Assumes: Only asynchronous bus operations; device clock pin held static low
// Notes:   Pin outputs lag the state register by one cycle, uniformly
//
// Functional notes
// - Deep sleep armed by refresh setup write, entered at next chip select rise.
// - Wake from deep sleep needs chip select low for at least 10 us.
// - After waking, wait 150 us initialization before normal operations.
// - Registers load defaults at power-up; update them only from standby.
// - Select-pin accesses: A[19:18] 10b bus, 00b refresh, 01b identity.
// - Read the memory array right after any configuration register access; the code skips this read when deep sleep is armed.
// - Synchronous register access is a burst of one with wait monitoring; the code makes asynchronous accesses only.
// - Software write: two reads, two writes at 3FFFFFh, array word unchanged.
// - Software read: same, but fourth operation is a read of the register.
// - Third operation data picks register: 0000h refresh, 0001h bus, 0002h identity.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps

module pcpc_ctrl
  import pcpc_pkg::*;
#(
  parameter logic [15:0] INIT_CYC      = INIT_CYC_DFLT,
  parameter int          DS_BIT        = 4,
  parameter logic        DS_ON_LEVEL   = 1'b0,
  parameter logic [15:0] BUS_RSVD_MASK = 16'h0000
) (
  // Clock and reset
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  // Software register port
  input  wire logic [3:0]  I_ADDR,
  input  wire logic [31:0] I_WDATA,
  input  wire logic        I_WR,
  input  wire logic        I_RD,
  output logic      [31:0] O_RDATA,
  // Device pins
  output logic             O_MEM_CLK,
  output logic             O_MEM_CE_N,
  output logic             O_MEM_WE_N,
  output logic             O_MEM_OE_N,
  output logic             O_MEM_ADV_N,
  output logic             O_MEM_CONFIG_REG_SELECT,
  output logic             O_MEM_LOW_BYTE_ENABLE_N,
  output logic             O_MEM_HIGH_BYTE_ENABLE_N,
  output logic      [5:0]  O_MEM_A_HI,
  input  wire logic [15:0] I_MEM_ADQ,
  output logic      [15:0] O_MEM_ADQ,
  output logic             O_MEM_ADQ_OE,
  input  wire logic        I_MEM_WAIT
);

  function automatic pcpc_op_s op_of(input logic [1:0] mode, input logic [2:0] idx);
    pcpc_op_s op;
    op = '{wr: 1'b0, config_reg_select: 1'b0, top: 1'b0, dsrc: DSRC_NONE, cap: 1'b0};
    if (!mode[1]) begin
      if (idx == 3'h0) begin
        op.config_reg_select  = 1'b1;
        op.wr   = !mode[0];
        op.dsrc = mode[0] ? DSRC_NONE : DSRC_WDATA;
        op.cap  = mode[0];
      end
    end else begin
      if (idx <= 3'h3) begin
        op.top = 1'b1;
      end
      if (idx == 3'h2) begin
        op.wr   = 1'b1;
        op.dsrc = DSRC_SEL;
      end
      if (idx == 3'h3) begin
        op.wr   = !mode[0];
        op.dsrc = mode[0] ? DSRC_NONE : DSRC_WDATA;
        op.cap  = mode[0];
      end
    end
    return op;
  endfunction

  function automatic logic [15:0] sw_code(input logic [1:0] sel);
    logic [15:0] code;
    code = SW_CODE_REFRESH;
    if (sel == SEL_BUS) begin
      code = SW_CODE_BUS;
    end else if (sel == SEL_IDENTITY) begin
      code = SW_CODE_IDENTITY;
    end
    return code;
  endfunction

  pcpc_state_e state;
  logic [15:0] tmr;
  logic [2:0]  op_idx;
  logic [1:0]  mode;
  logic [1:0]  sel;
  logic [15:0] wdata;
  logic [15:0] rd_reg;
  logic        seq_ds;
  logic        asleep;
  logic        refused;
  logic [15:0] adq_meta;
  logic [15:0] adq_sync;
  logic        wait_meta;
  logic        wait_sync;

  // Command decode
  wire         wr_ctrl   = I_WR && (I_ADDR == ADDR_CTRL);
  wire         cmd_start = wr_ctrl && I_WDATA[CTRL_START];
  wire         cmd_wake  = wr_ctrl && I_WDATA[CTRL_WAKE];
  wire  [1:0]  cmd_mode  = I_WDATA[CTRL_MODE_LSB +: 2];
  wire  [1:0]  cmd_sel   = I_WDATA[CTRL_SEL_LSB +: 2];
  wire         sel_ok    = (cmd_sel != 2'h3);
  // access only from standby, never asleep
  wire         idle      = (state == ST_IDLE);
  wire         go        = cmd_start && idle && !asleep && sel_ok;
  wire         wake_go   = cmd_wake && idle && asleep;
  wire         refuse    = (cmd_start && !go) || (cmd_wake && !wake_go);
  wire         clr_ref   = I_WR && (I_ADDR == ADDR_STATUS) && I_WDATA[STAT_REFUSED];
  wire         ds_req    = !cmd_mode[0] && (cmd_sel == SEL_REFRESH) && (wdata[DS_BIT] == DS_ON_LEVEL);

  // Current operation
  wire pcpc_op_s cur_op   = op_of(mode, op_idx);
  // trailing array read, skipped once deep sleep is armed
  wire  [2:0]  last_idx   = (mode[1] ? 3'h4 : 3'h1) - {2'b00, seq_ds};
  wire         op_last    = (op_idx == last_idx);
  wire         tmr_done   = (tmr == 16'h0000);
  wire  [15:0] wr_value   = (sel == SEL_BUS) ? (wdata & ~BUS_RSVD_MASK) : wdata;
  wire  [15:0] op_data    = (cur_op.dsrc == DSRC_SEL) ? sw_code(sel) : wr_value;
  wire  [21:0] op_addr    = cur_op.top ? TOP_ADDR :
                            cur_op.config_reg_select ? (ARRAY_RD_ADDR | (22'(sel) << (16 + CRE_SEL_LSB))) : ARRAY_RD_ADDR;

  // Pin next values
  wire         in_acc     = (state == ST_ADDR) || (state == ST_DATA);
  wire         next_ce_n  = !(in_acc || (state == ST_WAKE));
  wire         next_adv_n = (state != ST_ADDR);
  wire         next_we_n  = !((state == ST_DATA) && cur_op.wr);
  wire         next_oe_n  = !((state == ST_DATA) && !cur_op.wr);
  // Write data held through the gap so it outlives the strobe rise
  wire         next_dq_oe = (state == ST_ADDR) || (((state == ST_DATA) || (state == ST_GAP)) && cur_op.wr);
  wire  [15:0] next_dq    = (state == ST_ADDR) ? op_addr[15:0] : op_data;
  wire  [5:0]  next_a_hi  = in_acc ? op_addr[21:16] : 6'h00;
  wire         next_cre   = in_acc && cur_op.config_reg_select;
  wire         next_be_n  = !in_acc;

  // Software read mux
  wire  [31:0] stat_word  = 32'({refused, wait_sync, (state == ST_INIT), asleep, !idle});
  wire  [31:0] ctrl_word  = (32'(sel) << CTRL_SEL_LSB) | (32'(mode) << CTRL_MODE_LSB);
  wire  [31:0] rd_mux     = (I_ADDR == ADDR_CTRL)   ? ctrl_word :
                            (I_ADDR == ADDR_WDATA)  ? 32'(wdata) :
                            (I_ADDR == ADDR_RDATA)  ? 32'(rd_reg) :
                            (I_ADDR == ADDR_STATUS) ? stat_word : 32'h0000_0000;

  // Bus and wait synchronisers
  always_ff @(posedge I_CLOCK) begin
    adq_meta  <= I_MEM_ADQ;
    adq_sync  <= adq_meta;
    wait_meta <= I_MEM_WAIT;
    wait_sync <= wait_meta;
  end

  // Software registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      wdata   <= 16'h0000;
      refused <= 1'b0;
      O_RDATA <= 32'h0000_0000;
    end else begin
      if (I_WR && (I_ADDR == ADDR_WDATA)) begin
        wdata <= I_WDATA[15:0];
      end
      // Set wins over clear
      refused <= refuse || (refused && !clr_ref);
      O_RDATA <= I_RD ? rd_mux : 32'h0000_0000;
    end
  end

  // Sequencer
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state  <= ST_IDLE;
      tmr    <= 16'h0000;
      op_idx <= 3'h0;
      mode   <= MODE_CRE_WR;
      sel    <= SEL_REFRESH;
      seq_ds <= 1'b0;
      asleep <= 1'b0;
      rd_reg <= 16'h0000;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            mode   <= cmd_mode;
            sel    <= cmd_sel;
            seq_ds <= ds_req;
            op_idx <= 3'h0;
            tmr    <= ADV_CYC - 16'h0001;
            state  <= ST_ADDR;
          end else if (wake_go) begin
            tmr   <= WAKE_CYC - 16'h0001;
            state <= ST_WAKE;
          end
        end
        ST_ADDR: begin
          if (tmr_done) begin
            tmr   <= DATA_CYC - 16'h0001;
            state <= ST_DATA;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        ST_DATA: begin
          if (tmr_done) begin
            if (cur_op.cap) begin
              rd_reg <= adq_sync;
            end
            tmr   <= GAP_CYC - 16'h0001;
            state <= ST_GAP;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        ST_GAP: begin
          if (!tmr_done) begin
            tmr <= tmr - 16'h0001;
          end else if (op_last) begin
            asleep <= seq_ds;
            state  <= ST_IDLE;
          end else begin
            op_idx <= op_idx + 3'h1;
            tmr    <= ADV_CYC - 16'h0001;
            state  <= ST_ADDR;
          end
        end
        ST_WAKE: begin
          if (tmr_done) begin
            tmr   <= INIT_CYC - 16'h0001;
            state <= ST_INIT;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        ST_INIT: begin
          if (tmr_done) begin
            asleep <= 1'b0;
            state  <= ST_IDLE;
          end else begin
            tmr <= tmr - 16'h0001;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Pin registers
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      O_MEM_CLK                <= 1'b0;
      O_MEM_CE_N               <= 1'b1;
      O_MEM_WE_N               <= 1'b1;
      O_MEM_OE_N               <= 1'b1;
      O_MEM_ADV_N              <= 1'b1;
      O_MEM_CONFIG_REG_SELECT  <= 1'b0;
      O_MEM_LOW_BYTE_ENABLE_N  <= 1'b1;
      O_MEM_HIGH_BYTE_ENABLE_N <= 1'b1;
      O_MEM_A_HI               <= 6'h00;
      O_MEM_ADQ                <= 16'h0000;
      O_MEM_ADQ_OE             <= 1'b0;
    end else begin
      O_MEM_CLK                <= 1'b0;
      O_MEM_CE_N               <= next_ce_n;
      O_MEM_WE_N               <= next_we_n;
      O_MEM_OE_N               <= next_oe_n;
      O_MEM_ADV_N              <= next_adv_n;
      O_MEM_CONFIG_REG_SELECT  <= next_cre;
      O_MEM_LOW_BYTE_ENABLE_N  <= next_be_n;
      O_MEM_HIGH_BYTE_ENABLE_N <= next_be_n;
      O_MEM_A_HI               <= next_a_hi;
      O_MEM_ADQ                <= next_dq;
      O_MEM_ADQ_OE             <= next_dq_oe;
    end
  end

  // Assertion helpers
  logic [15:0] ce_low_cnt;
  logic [15:0] init_len;
  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      ce_low_cnt <= 16'h0000;
      init_len   <= 16'h0000;
    end else begin
      ce_low_cnt <= O_MEM_CE_N ? 16'h0000 : ce_low_cnt + 16'h0001;
      init_len   <= (state == ST_INIT) ? init_len + 16'h0001 : 16'h0000;
    end
  end

  a_wake_hold: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_INIT && $past(state) == ST_WAKE) |-> (!O_MEM_CE_N && ce_low_cnt >= WAKE_CYC - 16'h0001))
    else $error("wake low period too short");
  a_init_wait: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    ($past(state) == ST_INIT && state == ST_IDLE) |-> ($past(init_len) == INIT_CYC - 16'h0001 && !asleep))
    else $error("initialization wait wrong length");
  a_sleep_entry: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_GAP && tmr_done && op_last && seq_ds) |=> (asleep && O_MEM_CE_N))
    else $error("deep sleep not entered at chip select rise");
  a_standby_gap: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    $rose(O_MEM_CE_N) |=> O_MEM_CE_N)
    else $error("chip select high for under two cycles");
  a_cre_code: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_ADDR && cur_op.config_reg_select) |=> (O_MEM_CONFIG_REG_SELECT && O_MEM_A_HI[CRE_SEL_LSB +: 2] == $past(sel)))
    else $error("select-pin address code wrong");
  a_top_addr: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_ADDR && cur_op.top) |=> (O_MEM_ADQ == TOP_ADDR[15:0] && O_MEM_A_HI == TOP_ADDR[21:16] && !O_MEM_ADV_N))
    else $error("software sequence not at top address");
  a_sel_code: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_DATA && cur_op.dsrc == DSRC_SEL) |=> (O_MEM_ADQ == sw_code(sel) && !O_MEM_WE_N && O_MEM_ADQ_OE))
    else $error("third operation data code wrong");
  a_array_follow: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (state == ST_GAP && tmr_done && !op_last) |=> (state == ST_ADDR && op_idx == $past(op_idx) + 3'h1))
    else $error("sequence cut short");
  a_sleep_refuse: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (asleep && idle) |=> (state != ST_ADDR))
    else $error("access started while asleep");
  a_rd_status: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (I_RD && I_ADDR == ADDR_STATUS) |=> (O_RDATA[STAT_ASLEEP] == $past(asleep)))
    else $error("status read mismatch");

  c_sw_write: cover property (@(posedge I_CLOCK) disable iff (I_RST)
    state == ST_GAP && tmr_done && op_last && mode == MODE_SW_WR);
  c_sw_read: cover property (@(posedge I_CLOCK) disable iff (I_RST)
    state == ST_DATA && tmr_done && cur_op.cap && mode == MODE_SW_RD);
  c_cre_read: cover property (@(posedge I_CLOCK) disable iff (I_RST)
    state == ST_DATA && tmr_done && cur_op.cap && mode == MODE_CRE_RD);
  c_wake: cover property (@(posedge I_CLOCK) disable iff (I_RST)
    state == ST_INIT && tmr_done);

endmodule

//--- tb/pcpc_mem_model.sv
// Purpose: Behavioural model of the pseudo-static memory seen through its pins
// Assumes: Asynchronous accesses only; clock pin static
// Notes:   Released data lines show the inverse of the last driven word
`timescale 1ns/1ps

module pcpc_mem_model #(
  parameter logic [15:0] ID_CODE      = 16'h0c3a,
  parameter logic [15:0] REFRESH_DFLT = 16'h0010,
  parameter realtime     INIT_NS      = 150000.0
) (
  // Control pins
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_adv_n,
  input  wire logic        i_cre,
  // Address and data
  input  wire logic [5:0]  i_a_hi,
  input  wire logic [15:0] i_adq,
  output logic      [15:0] o_q,
  output logic             o_q_oe,
  output logic             o_wait
);
  // ID_CODE value is arbitrary
  logic [15:0] refresh_setup, bus_setup, code, last_q;
  logic [21:0] addr;
  logic        cre_l, armed, asleep, wr_act, viol;
  int          sw_cnt;
  realtime     t_low, t_init;
  wire         top    = (addr == 22'h3fffff);
  wire  [1:0]  sw_sel = (code == 16'h0000) ? 2'b00 : (code == 16'h0001) ? 2'b10 :
                        (code == 16'h0002) ? 2'b01 : 2'b11;
  wire         reg_rd = cre_l || (top && sw_cnt == 3);
  wire  [1:0]  rsel   = cre_l ? addr[19:18] : sw_sel;
  wire  [15:0] reg_v  = (rsel == 2'b00) ? refresh_setup : (rsel == 2'b01) ? ID_CODE :
                        (rsel == 2'b10) ? bus_setup : 16'h0000;
  wire  [15:0] rd_val = reg_rd ? reg_v : (addr[15:0] ^ 16'ha5a5);

  assign o_q_oe = !i_ce_n && !i_oe_n && !asleep;
  assign o_q    = o_q_oe ? rd_val : ~last_q;
  assign o_wait = o_q_oe;

  initial begin
    refresh_setup = REFRESH_DFLT;
    bus_setup = 16'h9d1f;
    {code, last_q, addr} = '0;
    {cre_l, armed, asleep, wr_act, viol} = '0;
    sw_cnt = 0;
    t_low = 0.0;
    t_init = 0.0;
  end

  task automatic wreg(input logic [1:0] s, input logic [15:0] v);
    if (s == 2'b00) begin
      refresh_setup = v;
      armed = (v[4] == 1'b0);
    end else if (s == 2'b10) begin
      bus_setup = v;
    end
  endtask

  always @(negedge o_q_oe) last_q = rd_val;

  always @(negedge i_adv_n) begin
    #2;
    addr = {i_a_hi, i_adq};
    cre_l = i_cre;
  end

  always @(negedge i_we_n) if (!i_ce_n) wr_act = 1'b1;

  always @(posedge i_we_n or posedge i_ce_n) begin
    if (wr_act && !asleep) begin
      if (cre_l) begin
        wreg(addr[19:18], i_adq);
      end else if (top && sw_cnt == 2) begin
        code = i_adq;
        sw_cnt = 3;
      end else if (top && sw_cnt == 3) begin
        wreg(sw_sel, i_adq);
        sw_cnt = 0;
      end else begin
        sw_cnt = 0;
      end
    end
    wr_act = 1'b0;
  end

  always @(posedge i_oe_n) begin
    if (!cre_l && top && sw_cnt < 2) sw_cnt = sw_cnt + 1;
    else sw_cnt = 0;
  end

  always @(negedge i_ce_n) begin
    t_low = $realtime;
    if (!asleep && $realtime < t_init) viol = 1'b1;
  end

  always @(posedge i_ce_n) begin
    #1;
    if (asleep && ($realtime - 1.0 - t_low) >= 10000.0) begin
      asleep = 1'b0;
      t_init = $realtime + INIT_NS;
    end else if (armed) begin
      asleep = 1'b1;
      armed = 1'b0;
    end
  end
endmodule

//--- tb/tb.sv
// Purpose: Self-checking bench for the configuration and power controller
// Assumes: Short initialization count, expected reads queued in order
// Notes:   Status polls ride the same queue but are not compared
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb
  import pcpc_pkg::*;
;
  localparam logic [15:0] INIT_SMALL = 16'h0014;
  localparam logic [15:0] ID_CODE    = 16'h0c3a; // Arbitrary value

  logic        I_CLOCK, I_RST, I_WR, I_RD, rd_d, c_v;
  logic [3:0]  I_ADDR;
  logic [31:0] I_WDATA, O_RDATA, last_rd, e_v;
  logic        ce_n, we_n, oe_n, adv_n, config_reg_select, lbe_n, hbe_n, adq_oe, q_oe, mwait, mclk;
  logic [5:0]  a_hi;
  logic [15:0] dq_out, q, adq, v, v2;
  logic [31:0] expq[$];
  bit          chkq[$];
  int          errors = 0;
  int          n_checks = 0;
  int          seed = 32'h78b532d8;

  assign adq = adq_oe ? dq_out : q;

  pcpc_ctrl #(.INIT_CYC(INIT_SMALL)) u_dut (
    .I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .O_MEM_CLK(mclk), .O_MEM_CE_N(ce_n), .O_MEM_WE_N(we_n),
    .O_MEM_OE_N(oe_n), .O_MEM_ADV_N(adv_n), .O_MEM_CONFIG_REG_SELECT(config_reg_select),
    .O_MEM_LOW_BYTE_ENABLE_N(lbe_n), .O_MEM_HIGH_BYTE_ENABLE_N(hbe_n), .O_MEM_A_HI(a_hi),
    .I_MEM_ADQ(adq), .O_MEM_ADQ(dq_out), .O_MEM_ADQ_OE(adq_oe), .I_MEM_WAIT(mwait));

  pcpc_mem_model #(.ID_CODE(ID_CODE), .INIT_NS(100.0)) u_mem (
    .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n), .i_adv_n(adv_n), .i_cre(config_reg_select),
    .i_a_hi(a_hi), .i_adq(adq), .o_q(q), .o_q_oe(q_oe), .o_wait(mwait));

  always #2.5 I_CLOCK = ~I_CLOCK;

  // Compares each read answer whose check flag is set with the oldest note
  always @(posedge I_CLOCK) begin
    rd_d <= I_RD;
    if (rd_d && expq.size() > 0) begin
      e_v = expq.pop_front();
      c_v = chkq.pop_front();
      if (c_v) `CHK(O_RDATA, e_v)
    end
  end

  // Clock static and both byte lanes on while a strobe is low
  always @(posedge I_CLOCK) begin
    if (!oe_n || !we_n) `CHK({mclk, lbe_n, hbe_n}, 3'b000)
  end

  task automatic results();
    if (errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    I_ADDR <= a;
    I_WDATA <= d;
    I_WR <= 1'b1;
    @(posedge I_CLOCK);
    I_WR <= 1'b0;
    @(posedge I_CLOCK);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input bit c);
    expq.push_back(e);
    chkq.push_back(c);
    I_ADDR <= a;
    I_RD <= 1'b1;
    @(posedge I_CLOCK);
    I_RD <= 1'b0;
    #1 last_rd = O_RDATA;
    @(posedge I_CLOCK);
  endtask

  // Bounded poll so a stuck controller cannot hang the run
  task automatic wait_idle(input logic [31:0] m);
    int k;
    k = 0;
    do begin
      rd(ADDR_STATUS, 32'h0, 1'b0);
      k++;
    end while ((last_rd & m) !== 32'h0 && k < 3000);
    if (k >= 3000) begin
      errors++;
      $display("[FAIL] %0t controller stuck busy", $time);
      results();
    end
  endtask

  task automatic op(input logic [1:0] m, input logic [1:0] s, input logic [15:0] d);
    wr(ADDR_WDATA, {16'h0000, d});
    wr(ADDR_CTRL, 32'h1 | (32'(m) << CTRL_MODE_LSB) | (32'(s) << CTRL_SEL_LSB));
    wait_idle(32'h1 << STAT_BUSY);
  endtask

  initial begin
    I_CLOCK = 1'b0;
    I_RST = 1'b1;
    I_ADDR = 4'h0;
    I_WDATA = 32'h0;
    I_WR = 1'b0;
    I_RD = 1'b0;
    rd_d = 1'b0;
    repeat (4) @(posedge I_CLOCK);
    I_RST <= 1'b0;
    @(posedge I_CLOCK);
    rd(ADDR_STATUS, 32'h0, 1'b1);
    rd(4'h1, 32'h0, 1'b1);
    op(MODE_CRE_RD, SEL_BUS, 16'h0000);
    rd(ADDR_RDATA, 32'h0000_9d1f, 1'b1);
    v = 16'($random(seed));
    op(MODE_SW_WR, SEL_BUS, v);
    `CHK(u_mem.bus_setup, v)
    rd(ADDR_WDATA, {16'h0000, v}, 1'b1);
    rd(ADDR_CTRL, (32'(MODE_SW_WR) << CTRL_MODE_LSB) | (32'(SEL_BUS) << CTRL_SEL_LSB), 1'b1);
    op(MODE_CRE_RD, SEL_BUS, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, v}, 1'b1);
    v2 = 16'($random(seed));
    op(MODE_CRE_WR, SEL_BUS, v2);
    `CHK(u_mem.bus_setup, v2)
    op(MODE_SW_RD, SEL_BUS, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, v2}, 1'b1);
    op(MODE_SW_RD, SEL_IDENTITY, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, ID_CODE}, 1'b1);
    op(MODE_CRE_WR, SEL_IDENTITY, v);
    op(MODE_CRE_RD, SEL_IDENTITY, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, ID_CODE}, 1'b1);
    v = 16'($random(seed)) | 16'h0010;
    op(MODE_SW_WR, SEL_REFRESH, v);
    op(MODE_CRE_RD, SEL_REFRESH, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, v}, 1'b1);
    v2 = 16'($random(seed)) | 16'h0010;
    op(MODE_CRE_WR, SEL_REFRESH, v2);
    op(MODE_SW_RD, SEL_REFRESH, 16'h0000);
    rd(ADDR_RDATA, {16'h0000, v2}, 1'b1);
    // Selection code 3 must be turned away
    wr(ADDR_CTRL, 32'h1 | (32'h3 << CTRL_SEL_LSB));
    rd(ADDR_STATUS, 32'h1 << STAT_REFUSED, 1'b1);
    wr(ADDR_STATUS, 32'h1 << STAT_REFUSED);
    rd(ADDR_STATUS, 32'h0, 1'b1);
    op(MODE_CRE_WR, SEL_REFRESH, 16'h0000);
    rd(ADDR_STATUS, 32'h1 << STAT_ASLEEP, 1'b1);
    `CHK(u_mem.asleep, 1'b1)
    wr(ADDR_CTRL, 32'h1 | (32'(MODE_CRE_RD) << CTRL_MODE_LSB));
    rd(ADDR_STATUS, (32'h1 << STAT_ASLEEP) | (32'h1 << STAT_REFUSED), 1'b1);
    wr(ADDR_STATUS, 32'h1 << STAT_REFUSED);
    wr(ADDR_CTRL, 32'h1 << CTRL_WAKE);
    rd(ADDR_STATUS, (32'h1 << STAT_ASLEEP) | (32'h1 << STAT_BUSY), 1'b1);
    wait_idle(32'h7);
    `CHK(u_mem.asleep, 1'b0)
    op(MODE_CRE_RD, SEL_BUS, 16'h0000);
    `CHK(u_mem.viol, 1'b0)
    rd(ADDR_STATUS, 32'h0, 1'b1);
    repeat (4) @(posedge I_CLOCK);
    results();
  end
endmodule
